// ==== hw/mmic_arbiter.v ====
// Priority resolver for the interrupt controller: picks the best source to serve.
// Assumes the caller supplies per-source request, in-service and priority fields.
`timescale 1ns/1ps
`default_nettype none
`include "mmic_defs.vh"

module mmic_arbiter #(
	parameter NSRC = 8
) (
	// Sources
	input wire [NSRC-1:0] i_req,
	input wire [NSRC-1:0] i_insv,
	input wire [NSRC-1:0] i_same_ok,
	input wire [NSRC*3-1:0] i_pri,
	input wire [2:0] i_pmask,
	// Result
	output reg o_hit,
	output reg [2:0] o_idx,
	output reg o_isv_hit,
	output reg [2:0] o_isv_idx
);
	// ****************************************
	// Scan; ties go to the lower index
	// ****************************************
	integer k;
	reg [3:0] best_pri;
	reg [3:0] isv_pri;
	reg [2:0] p;
	always @* begin
		o_hit = 1'b0;
		o_idx = 3'h0;
		o_isv_hit = 1'b0;
		o_isv_idx = 3'h0;
		best_pri = 4'h8;
		isv_pri = 4'h8;
		for (k = NSRC - 1; k >= 0; k = k - 1) begin
			p = i_pri[k*3 +: 3];
			if (i_insv[k] && {1'b0, p} <= isv_pri) begin
				isv_pri = {1'b0, p};
				o_isv_idx = k[2:0];
				o_isv_hit = 1'b1;
			end
			if (i_req[k] && {1'b0, p} <= best_pri) begin
				best_pri = {1'b0, p};
				o_idx = k[2:0];
			end
		end
		// Higher or equal priority in service blocks, unless it is the same source in
		// special nested mode
		if (best_pri != 4'h8 && best_pri[2:0] <= i_pmask) begin
			o_hit = (best_pri < isv_pri) ||
				(best_pri == isv_pri && o_idx == o_isv_idx && i_same_ok[o_idx]);
		end
	end
endmodule
`default_nettype wire

// ==== hw/mmic_defs.vh ====
// Constants for the master-mode interrupt controller: register map, fields, vectors.
// Assumes a 32-bit AXI4-Lite slave port, one register per aligned word.
`ifndef MMIC_DEFS_VH
`define MMIC_DEFS_VH

// ****************************************
// Register byte addresses (index times four)
// ****************************************
`define MMIC_EOI_ADDR 8'h88
`define MMIC_POLL_ADDR 8'h90
`define MMIC_PEEK_ADDR 8'h98
`define MMIC_MASK_ADDR 8'ha0
`define MMIC_PMSK_ADDR 8'ha8
`define MMIC_INSV_ADDR 8'hb0
`define MMIC_REQ_ADDR 8'hb8
`define MMIC_STAT_ADDR 8'hc0
`define MMIC_TCR_ADDR 8'hc8
`define MMIC_D0CR_ADDR 8'hd0
`define MMIC_D1CR_ADDR 8'hd8
`define MMIC_X0CR_ADDR 8'he0
`define MMIC_X1CR_ADDR 8'he8
`define MMIC_X2CR_ADDR 8'hf0
`define MMIC_X3CR_ADDR 8'hf8
`define MMIC_RELOC_ADDR 8'hfc

// ****************************************
// Source indexes, vector types, fields
// ****************************************
`define MMIC_NSRC 7
`define MMIC_SRC_TMR 3'h0
`define MMIC_SRC_D0 3'h2
`define MMIC_SRC_D1 3'h3
`define MMIC_SRC_X0 3'h4
`define MMIC_SRC_X1 3'h5
`define MMIC_SRC_X2 3'h6
`define MMIC_SRC_X3 3'h7
`define MMIC_VEC_NMI 5'h02
`define MMIC_VEC_TMR0 5'h08
`define MMIC_VEC_TMR1 5'h12
`define MMIC_VEC_TMR2 5'h13
`define MMIC_VEC_D0 5'h0a
`define MMIC_VEC_D1 5'h0b
`define MMIC_VEC_X0 5'h0c
`define MMIC_VEC_X1 5'h0d
`define MMIC_VEC_X2 5'h0e
`define MMIC_VEC_X3 5'h0f
`define MMIC_CR_MSK 3
`define MMIC_CR_LTM 4
`define MMIC_CR_CAS 5
`define MMIC_CR_SFN 6
`define MMIC_CR_RST 7'h0f
`define MMIC_PRI_LOW 3'h7
`define MMIC_EOI_NSPEC 15
`define MMIC_POLL_REQ 15
`define MMIC_RELOC_SLV 14
`define MMIC_RESP_OKAY 2'h0
`define MMIC_RESP_SLVERR 2'h2

`endif

// ==== hw/mmic_top.v ====
// Master-mode interrupt controller with an AXI4-Lite register port.
// Assumes requests and pins are synchronous to I_CLK_SYS; the CPU core pulses
// the acknowledge input and reads the vector when O_VECTOR_VALID pulses, one cycle later or three for a cascaded source.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mmic_defs.vh"

module mmic_top (
	// Clock and reset
	input wire I_CLK_SYS,
	input wire I_RST,
	// AXI4-Lite write
	input wire [7:0] I_AWADDR,
	input wire I_AWVALID,
	output reg O_AWREADY,
	input wire [31:0] I_WDATA,
	input wire [3:0] I_WSTRB,
	input wire I_WVALID,
	output reg O_WREADY,
	output reg [1:0] O_BRESP,
	output reg O_BVALID,
	input wire I_BREADY,
	// AXI4-Lite read
	input wire [7:0] I_ARADDR,
	input wire I_ARVALID,
	output reg O_ARREADY,
	output reg [31:0] O_RDATA,
	output reg [1:0] O_RRESP,
	output reg O_RVALID,
	input wire I_RREADY,
	// Internal sources, one-cycle pulses
	input wire [2:0] I_TMR_REQ,
	input wire [1:0] I_DMA_REQ,
	// External pins
	input wire I_NMI,
	input wire I_EXT_REQUEST_ZERO,
	input wire I_EXT_REQUEST_ONE,
	input wire I_EXT_REQUEST_TWO_OR_ACK_ZERO,
	output reg O_EXT_REQUEST_TWO_OR_ACK_ZERO,
	output reg O_EXT_REQUEST_TWO_OR_ACK_ZERO_OE,
	input wire I_EXT_REQUEST_THREE_OR_ACK_ONE,
	output reg O_EXT_REQUEST_THREE_OR_ACK_ONE,
	output reg O_EXT_REQUEST_THREE_OR_ACK_ONE_OE,
	// CPU core side
	input wire I_INTERRUPT_ACKNOWLEDGE_CYCLE,
	input wire [7:0] I_CAS_VECTOR,
	output reg O_INT_REQ,
	output reg O_NMI_REQ,
	output reg [7:0] O_VECTOR,
	output reg O_VECTOR_VALID,
	output reg O_SLAVE_MODE,
	output reg O_DMA_HALT
);
	// ****************************************
	// State
	// ****************************************
	localparam ACK_IDLE = 2'h0;
	localparam ACK_ONE = 2'h1;
	localparam ACK_TWO = 2'h2;
	reg [6:0] cr_q [0:7];
	reg [2:0] tmr_req_q;
	reg [1:0] dma_req_q;
	reg [7:0] insv_q;
	reg [2:0] pmask_q;
	reg [3:0] edge_arm_q;
	reg nmi_prev_q;
	reg slave_q;
	reg [1:0] ack_st_q;
	reg [2:0] ack_idx_q;
	reg [7:0] aw_addr_q;
	reg aw_have_q;
	reg [31:0] w_data_q;
	reg w_have_q;
	wire [3:0] ext_pin;
	wire [7:0] req_vec;
	wire [7:0] same_ok;
	wire [23:0] pri_vec;
	wire hit;
	wire [2:0] win;
	wire isv_hit;
	wire [2:0] isv_top;
	genvar g;

	// ****************************************
	// Helpers
	// ****************************************
	function [4:0] vec_of;
		input [2:0] idx;
		input [2:0] tr;
		begin
			case (idx)
				`MMIC_SRC_TMR: vec_of = tr[0] ? `MMIC_VEC_TMR0 : (tr[1] ? `MMIC_VEC_TMR1 : `MMIC_VEC_TMR2);
				`MMIC_SRC_D0: vec_of = `MMIC_VEC_D0;
				`MMIC_SRC_D1: vec_of = `MMIC_VEC_D1;
				`MMIC_SRC_X0: vec_of = `MMIC_VEC_X0;
				`MMIC_SRC_X1: vec_of = `MMIC_VEC_X1;
				`MMIC_SRC_X2: vec_of = `MMIC_VEC_X2;
				default: vec_of = `MMIC_VEC_X3;
			endcase
		end
	endfunction

	function [3:0] src_of_vec;
		input [4:0] v;
		begin
			case (v)
				`MMIC_VEC_TMR0, `MMIC_VEC_TMR1, `MMIC_VEC_TMR2: src_of_vec = {1'b1, `MMIC_SRC_TMR};
				`MMIC_VEC_D0: src_of_vec = {1'b1, `MMIC_SRC_D0};
				`MMIC_VEC_D1: src_of_vec = {1'b1, `MMIC_SRC_D1};
				`MMIC_VEC_X0: src_of_vec = {1'b1, `MMIC_SRC_X0};
				`MMIC_VEC_X1: src_of_vec = {1'b1, `MMIC_SRC_X1};
				`MMIC_VEC_X2: src_of_vec = {1'b1, `MMIC_SRC_X2};
				`MMIC_VEC_X3: src_of_vec = {1'b1, `MMIC_SRC_X3};
				default: src_of_vec = 4'h0;
			endcase
		end
	endfunction

	// ****************************************
	// Request gathering
	// ****************************************
	// Pins two and three only request when their pair is not in cascade
	assign ext_pin = {I_EXT_REQUEST_THREE_OR_ACK_ONE & ~cr_q[5][`MMIC_CR_CAS],
		I_EXT_REQUEST_TWO_OR_ACK_ZERO & ~cr_q[4][`MMIC_CR_CAS],
		I_EXT_REQUEST_ONE, I_EXT_REQUEST_ZERO};

	// Internal sources behave the same whatever the pin mode; mask bits gate them
	assign req_vec[0] = (|tmr_req_q) & ~cr_q[0][`MMIC_CR_MSK];
	assign req_vec[1] = 1'b0;
	assign req_vec[2] = dma_req_q[0] & ~cr_q[2][`MMIC_CR_MSK];
	assign req_vec[3] = dma_req_q[1] & ~cr_q[3][`MMIC_CR_MSK];
	generate
		for (g = 0; g < 4; g = g + 1) begin : gx
			// Level mode requests continuously; edge mode waits for re-arm
			assign req_vec[4+g] = ext_pin[g] & ~cr_q[4+g][`MMIC_CR_MSK] &
				(cr_q[4+g][`MMIC_CR_LTM] | edge_arm_q[g]);
		end
		for (g = 0; g < 8; g = g + 1) begin : gp
			// Three-bit priority per source
			assign pri_vec[g*3 +: 3] = cr_q[g][2:0];
			assign same_ok[g] = (g >= 4 && g <= 5) ? cr_q[g][`MMIC_CR_SFN] : 1'b0;
		end
	endgenerate

	mmic_arbiter #(
		.NSRC(8)
	) u_arb (
		.i_req(req_vec),
		.i_insv(insv_q),
		.i_same_ok(same_ok),
		.i_pri(pri_vec),
		.i_pmask(pmask_q),
		.o_hit(hit),
		.o_idx(win),
		.o_isv_hit(isv_hit),
		.o_isv_idx(isv_top)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	wire wr_go = aw_have_q && w_have_q && !O_BVALID;
	wire rd_go = I_ARVALID && O_ARREADY;
	wire poll_rd = rd_go && I_ARADDR == `MMIC_POLL_ADDR && hit;
	wire ack_take = ack_st_q == ACK_IDLE && I_INTERRUPT_ACKNOWLEDGE_CYCLE && hit && !slave_q;
	wire cas_win = (win == `MMIC_SRC_X0 || win == `MMIC_SRC_X1) && cr_q[win][`MMIC_CR_CAS];
	wire [15:0] poll_word = {hit, 10'h000, vec_of(win, tmr_req_q)};
	wire [3:0] spec = src_of_vec(w_data_q[4:0]);
	reg [31:0] rd_mux;
	always @* begin
		case (I_ARADDR)
			`MMIC_POLL_ADDR, `MMIC_PEEK_ADDR: rd_mux = {16'h0000, poll_word};
			`MMIC_MASK_ADDR: rd_mux = {24'h000000, cr_q[7][3], cr_q[6][3], cr_q[5][3],
				cr_q[4][3], cr_q[3][3], cr_q[2][3], 1'b0, cr_q[0][3]};
			`MMIC_PMSK_ADDR: rd_mux = {29'h0, pmask_q};
			`MMIC_INSV_ADDR: rd_mux = {24'h000000, insv_q};
			`MMIC_REQ_ADDR: rd_mux = {24'h000000, ext_pin, dma_req_q, 1'b0, |tmr_req_q};
			`MMIC_STAT_ADDR: rd_mux = {28'h0, tmr_req_q, O_DMA_HALT};
			`MMIC_TCR_ADDR: rd_mux = {25'h0, cr_q[0]};
			`MMIC_D0CR_ADDR: rd_mux = {25'h0, cr_q[2]};
			`MMIC_D1CR_ADDR: rd_mux = {25'h0, cr_q[3]};
			`MMIC_X0CR_ADDR: rd_mux = {25'h0, cr_q[4]};
			`MMIC_X1CR_ADDR: rd_mux = {25'h0, cr_q[5]};
			`MMIC_X2CR_ADDR: rd_mux = {25'h0, cr_q[6]};
			`MMIC_X3CR_ADDR: rd_mux = {25'h0, cr_q[7]};
			`MMIC_RELOC_ADDR: rd_mux = {17'h0, slave_q, 14'h0};
			default: rd_mux = 32'h00000000;
		endcase
	end
	wire rd_ok = I_ARADDR[1:0] == 2'h0 && I_ARADDR >= `MMIC_EOI_ADDR && I_ARADDR != `MMIC_EOI_ADDR;
	wire wr_ok = aw_addr_q[1:0] == 2'h0 && aw_addr_q >= `MMIC_EOI_ADDR &&
		aw_addr_q != `MMIC_POLL_ADDR && aw_addr_q != `MMIC_PEEK_ADDR;

	// ****************************************
	// Clocked logic
	// ****************************************
	integer i;
	always @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			for (i = 0; i < 8; i = i + 1) begin
				cr_q[i] <= `MMIC_CR_RST;
			end
			tmr_req_q <= 3'h0;
			dma_req_q <= 2'h0;
			insv_q <= 8'h00;
			pmask_q <= `MMIC_PRI_LOW;
			edge_arm_q <= 4'hf;
			nmi_prev_q <= 1'b0;
			slave_q <= 1'b0;
			ack_st_q <= ACK_IDLE;
			ack_idx_q <= 3'h0;
			aw_addr_q <= 8'h00;
			aw_have_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_have_q <= 1'b0;
			O_AWREADY <= 1'b0;
			O_WREADY <= 1'b0;
			O_BVALID <= 1'b0;
			O_BRESP <= `MMIC_RESP_OKAY;
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b0;
			O_RRESP <= `MMIC_RESP_OKAY;
			O_RDATA <= 32'h00000000;
			O_EXT_REQUEST_TWO_OR_ACK_ZERO <= 1'b1;
			O_EXT_REQUEST_TWO_OR_ACK_ZERO_OE <= 1'b0;
			O_EXT_REQUEST_THREE_OR_ACK_ONE <= 1'b1;
			O_EXT_REQUEST_THREE_OR_ACK_ONE_OE <= 1'b0;
			O_INT_REQ <= 1'b0;
			O_NMI_REQ <= 1'b0;
			O_VECTOR <= 8'h00;
			O_VECTOR_VALID <= 1'b0;
			O_SLAVE_MODE <= 1'b0;
			O_DMA_HALT <= 1'b0;
		end else begin
			// Bus handshakes: address and data taken in either order
			O_AWREADY <= !aw_have_q && !O_AWREADY;
			O_WREADY <= !w_have_q && !O_WREADY;
			if (I_AWVALID && O_AWREADY) begin
				aw_addr_q <= I_AWADDR;
				aw_have_q <= 1'b1;
			end
			if (I_WVALID && O_WREADY) begin
				w_data_q <= I_WDATA;
				w_have_q <= 1'b1;
			end
			if (O_BVALID && I_BREADY) begin
				O_BVALID <= 1'b0;
			end
			O_ARREADY <= !O_RVALID && !O_ARREADY;
			if (O_RVALID && I_RREADY) begin
				O_RVALID <= 1'b0;
			end
			if (rd_go) begin
				O_RVALID <= 1'b1;
				O_RDATA <= rd_ok ? rd_mux : 32'h00000000;
				O_RRESP <= rd_ok ? `MMIC_RESP_OKAY : `MMIC_RESP_SLVERR;
			end

			// Sticky internal requests; a new pulse wins over the clearing acknowledge
			for (i = 0; i < 3; i = i + 1) begin
				if (I_TMR_REQ[i]) begin
					tmr_req_q[i] <= 1'b1;
				end else if ((ack_take || poll_rd) && win == `MMIC_SRC_TMR &&
						vec_of(win, tmr_req_q) == vec_of(win, 3'h1 << i)) begin
					tmr_req_q[i] <= 1'b0;
				end
			end
			for (i = 0; i < 2; i = i + 1) begin
				if (I_DMA_REQ[i]) begin
					dma_req_q[i] <= 1'b1;
				end else if ((ack_take || poll_rd) && win == `MMIC_SRC_D0 + i[2:0]) begin
					dma_req_q[i] <= 1'b0;
				end
			end
			// Edge inputs re-arm after a low cycle
			for (i = 0; i < 4; i = i + 1) begin
				if (!ext_pin[i]) begin
					edge_arm_q[i] <= 1'b1;
				end else if ((ack_take || poll_rd) && win == `MMIC_SRC_X0 + i[2:0]) begin
					edge_arm_q[i] <= 1'b0;
				end
			end

			// Register writes
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				O_BVALID <= 1'b1;
				O_BRESP <= wr_ok ? `MMIC_RESP_OKAY : `MMIC_RESP_SLVERR;
				if (I_WSTRB != 4'h0) begin
				case (aw_addr_q)
					`MMIC_EOI_ADDR: begin
						// End-of-service command; next in-service source then wins
						if (w_data_q[`MMIC_EOI_NSPEC]) begin
							if (isv_hit) begin
								insv_q[isv_top] <= 1'b0;
							end
						end else if (spec[3]) begin
							insv_q[spec[2:0]] <= 1'b0;
						end
					end
					`MMIC_MASK_ADDR: begin
						for (i = 0; i < 8; i = i + 1) begin
							cr_q[i][`MMIC_CR_MSK] <= w_data_q[i];
						end
					end
					`MMIC_PMSK_ADDR: pmask_q <= w_data_q[2:0];
					`MMIC_INSV_ADDR: insv_q <= w_data_q[7:0];
					// A pulse in the same cycle as a clearing write still lands
					`MMIC_REQ_ADDR: dma_req_q <= w_data_q[3:2] | I_DMA_REQ;
					`MMIC_STAT_ADDR: O_DMA_HALT <= w_data_q[0];
					`MMIC_TCR_ADDR: cr_q[0] <= {3'h0, w_data_q[3:0]};
					`MMIC_D0CR_ADDR: cr_q[2] <= {3'h0, w_data_q[3:0]};
					`MMIC_D1CR_ADDR: cr_q[3] <= {3'h0, w_data_q[3:0]};
					// Pair mode bits of pins zero and one
					`MMIC_X0CR_ADDR: cr_q[4] <= w_data_q[6:0];
					`MMIC_X1CR_ADDR: cr_q[5] <= w_data_q[6:0];
					`MMIC_X2CR_ADDR: cr_q[6] <= {2'h0, w_data_q[4:0]};
					`MMIC_X3CR_ADDR: cr_q[7] <= {2'h0, w_data_q[4:0]};
					`MMIC_RELOC_ADDR: slave_q <= w_data_q[`MMIC_RELOC_SLV];
					default: ;
				endcase
				end
			end

			// Acknowledge or poll sets in-service of the winner
			// Placed after the writes so a set beats a clear in the same cycle
			if (ack_take || poll_rd) begin
				insv_q[win] <= 1'b1;
			end

			// NMI is never masked and halts DMA
			nmi_prev_q <= I_NMI;
			O_NMI_REQ <= I_NMI && !nmi_prev_q;
			if (I_NMI && !nmi_prev_q) begin
				O_DMA_HALT <= 1'b1;
			end
			O_SLAVE_MODE <= slave_q;
			O_INT_REQ <= hit && !slave_q && ack_st_q == ACK_IDLE;

			// Acknowledge sequencing; cascade runs two cycles on its own ack pin
			O_VECTOR_VALID <= 1'b0;
			O_EXT_REQUEST_TWO_OR_ACK_ZERO_OE <= cr_q[4][`MMIC_CR_CAS];
			O_EXT_REQUEST_THREE_OR_ACK_ONE_OE <= cr_q[5][`MMIC_CR_CAS];
			case (ack_st_q)
				ACK_IDLE: begin
					if (ack_take) begin
						if (cas_win) begin
							ack_idx_q <= win;
							ack_st_q <= ACK_ONE;
							O_EXT_REQUEST_TWO_OR_ACK_ZERO <= win != `MMIC_SRC_X0;
							O_EXT_REQUEST_THREE_OR_ACK_ONE <= win != `MMIC_SRC_X1;
						end else begin
							O_VECTOR <= {3'h0, vec_of(win, tmr_req_q)};
							O_VECTOR_VALID <= 1'b1;
						end
					end
				end
				ACK_ONE: begin
					ack_st_q <= ACK_TWO;
				end
				ACK_TWO: begin
					// Vector sampled from the external controller in the second cycle
					O_VECTOR <= I_CAS_VECTOR;
					O_VECTOR_VALID <= 1'b1;
					O_EXT_REQUEST_TWO_OR_ACK_ZERO <= 1'b1;
					O_EXT_REQUEST_THREE_OR_ACK_ONE <= 1'b1;
					ack_st_q <= ACK_IDLE;
				end
				default: ack_st_q <= ACK_IDLE;
			endcase
		end
	end
	// Cascaded sources may need up to three end commands in software
endmodule
`default_nettype wire

// ==== test/mmic_ext_ctrl_model.sv ====
// Model of a cascaded external interrupt controller on one pin pair.
// Assumes the acknowledge pin idles high when the pair is not driving it.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// External controller
// ****************************************
module mmic_ext_ctrl_model (
	// Clock
	input wire logic i_clk,
	// Bench control
	input wire logic i_fire,
	input wire logic [7:0] i_vec,
	// Pins
	input wire logic i_ack_n,
	output logic o_req,
	output logic [7:0] o_cas
);
	logic second_q = 1'b0;
	logic req_q = 1'b0;
	logic [7:0] junk_q = 8'h5a;
	assign o_req = req_q;
	// Bus shows a changing pattern outside the second cycle, so a late sample is caught
	assign o_cas = (second_q && !i_ack_n) ? i_vec : junk_q;
	always @(posedge i_clk) begin
		junk_q <= ~junk_q ^ 8'h3c;
		second_q <= !i_ack_n && !second_q;
		if (i_fire) begin
			req_q <= 1'b1;
		end else if (second_q && !i_ack_n) begin
			req_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== test/mmic_props.sv ====
// Checker for the interrupt controller top level ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Port checker
// ****************************************
module mmic_props (
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	// Register bus
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic [31:0] O_RDATA,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	// Pins and core side
	input wire logic I_NMI,
	input wire logic O_NMI_REQ,
	input wire logic O_DMA_HALT,
	input wire logic O_EXT_REQUEST_TWO_OR_ACK_ZERO,
	input wire logic O_EXT_REQUEST_TWO_OR_ACK_ZERO_OE,
	input wire logic I_INTERRUPT_ACKNOWLEDGE_CYCLE,
	input wire logic O_INT_REQ,
	input wire logic O_VECTOR_VALID,
	input wire logic O_SLAVE_MODE
);
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);

	// Second acknowledge cycle, then the captured vector
	sequence ack_two_s;
		!O_EXT_REQUEST_TWO_OR_ACK_ZERO ##1 (O_EXT_REQUEST_TWO_OR_ACK_ZERO && O_VECTOR_VALID);
	endsequence

	rd_answer_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
		else $error("read answer late");
	rd_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read data not held");
	wr_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
		else $error("write response dropped");
	ack_pair_a: assert property (!O_EXT_REQUEST_TWO_OR_ACK_ZERO |-> O_EXT_REQUEST_TWO_OR_ACK_ZERO_OE)
		else $error("ack pin low outside cascade");
	ack_two_a: assert property ($fell(O_EXT_REQUEST_TWO_OR_ACK_ZERO) |-> ##1 ack_two_s)
		else $error("cascade ack not two cycles");
	vec_pulse_a: assert property (O_VECTOR_VALID |=> !O_VECTOR_VALID)
		else $error("vector valid too long");
	ack_answer_a: assert property (I_INTERRUPT_ACKNOWLEDGE_CYCLE && O_INT_REQ |-> ##[1:3] O_VECTOR_VALID)
		else $error("no vector after acknowledge");
	nmi_pulse_a: assert property ($rose(I_NMI) |-> ##[1:2] O_NMI_REQ ##1 !O_NMI_REQ)
		else $error("nmi request missing");
	nmi_halt_a: assert property (O_NMI_REQ |-> ##[0:1] O_DMA_HALT)
		else $error("dma halt not set");
	slave_quiet_a: assert property (O_SLAVE_MODE && $past(O_SLAVE_MODE) |-> !O_INT_REQ)
		else $error("interrupt while slave");
endmodule

bind mmic_top mmic_props u_props (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_ARVALID(I_ARVALID),
	.O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA),
	.O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_NMI(I_NMI), .O_NMI_REQ(O_NMI_REQ),
	.O_DMA_HALT(O_DMA_HALT), .O_EXT_REQUEST_TWO_OR_ACK_ZERO(O_EXT_REQUEST_TWO_OR_ACK_ZERO),
	.O_EXT_REQUEST_TWO_OR_ACK_ZERO_OE(O_EXT_REQUEST_TWO_OR_ACK_ZERO_OE),
	.I_INTERRUPT_ACKNOWLEDGE_CYCLE(I_INTERRUPT_ACKNOWLEDGE_CYCLE), .O_INT_REQ(O_INT_REQ),
	.O_VECTOR_VALID(O_VECTOR_VALID), .O_SLAVE_MODE(O_SLAVE_MODE));
`default_nettype wire

// ==== test/tb_master_mode_interrupt_controller.sv ====
// Self-checking bench for the interrupt controller top level.
// Assumes a 10 MHz clock and the register map of the defines header.
`timescale 1ns/1ps
`default_nettype none
`include "mmic_defs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

// ****************************************
// Bench
// ****************************************
module tb_master_mode_interrupt_controller;
	logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic ack = 0, nmi = 0, fire = 0, x0 = 0, x1 = 0;
	logic [7:0] awaddr = 0, araddr = 0, pvec = 0;
	logic [31:0] wdata = 0;
	logic [2:0] tmr = 0;
	logic [1:0] dma = 0;
	wire awready, wready, bvalid, arready, rvalid, int_req, nmi_req, vvalid, slave, halt;
	wire a0, a0oe, a1, a1oe, preq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] vec, cas;
	// Idle pins float high through a pull-up
	wire pin2 = a0oe ? a0 : 1'b1;
	wire pin3 = a1oe ? a1 : 1'b1;
	integer n_errors = 0, num_checks = 0, cyc = 0;
	logic [65:0] qr[$], e66;
	logic [1:0] qb[$], e2;
	logic [7:0] qv[$], e8;
	localparam logic [31:0] PM = 32'h801f;

	mmic_top dut (.I_CLK_SYS(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
		.O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid),
		.O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
		.I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
		.O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_TMR_REQ(tmr),
		.I_DMA_REQ(dma), .I_NMI(nmi), .I_EXT_REQUEST_ZERO(preq | x0), .I_EXT_REQUEST_ONE(x1),
		.I_EXT_REQUEST_TWO_OR_ACK_ZERO(pin2), .O_EXT_REQUEST_TWO_OR_ACK_ZERO(a0),
		.O_EXT_REQUEST_TWO_OR_ACK_ZERO_OE(a0oe), .I_EXT_REQUEST_THREE_OR_ACK_ONE(pin3),
		.O_EXT_REQUEST_THREE_OR_ACK_ONE(a1), .O_EXT_REQUEST_THREE_OR_ACK_ONE_OE(a1oe),
		.I_INTERRUPT_ACKNOWLEDGE_CYCLE(ack), .I_CAS_VECTOR(cas), .O_INT_REQ(int_req),
		.O_NMI_REQ(nmi_req), .O_VECTOR(vec), .O_VECTOR_VALID(vvalid), .O_SLAVE_MODE(slave),
		.O_DMA_HALT(halt));
	mmic_ext_ctrl_model u_ext (.i_clk(clk), .i_fire(fire), .i_vec(pvec), .i_ack_n(pin2),
		.o_req(preq), .o_cas(cas));

	initial forever #50 clk = ~clk;

	task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
		qb.push_back(r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rd(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] r);
		qr.push_back({m, r, e});
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask

	task automatic intack(input [7:0] v);
		qv.push_back(v);
		do @(posedge clk); while (!int_req);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		do @(posedge clk); while (!vvalid);
	endtask

	task automatic fire_ext(input [7:0] v);
		pvec <= v;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask

	task automatic test_done;
		if (n_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Results are compared in arrival order against the notes queued by the drivers
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rvalid && rready) begin
			e66 = qr.pop_front();
			`CHK("rresp", e66[33:32], rresp)
			`CHK("rdata", e66[31:0] & e66[65:34], rdata & e66[65:34])
		end
		// Pop once; the compare macro names its expected value twice
		if (bvalid && bready) begin
			e2 = qb.pop_front();
			`CHK("bresp", e2, bresp)
		end
		if (vvalid) begin
			e8 = qv.pop_front();
			`CHK("vector", e8, vec)
		end
		if (cyc == 20000) begin
			n_errors++;
			test_done;
		end
	end

	initial begin
		logic [7:0] v;
		void'($urandom(32'hb6f6));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(`MMIC_X0CR_ADDR, 32'h0f, '1, 2'h0);
		rd(`MMIC_PMSK_ADDR, 32'h7, '1, 2'h0);
		rd(`MMIC_INSV_ADDR, 32'h0, '1, 2'h0);
		rd(8'h04, 32'h0, 32'h0, 2'h2);
		wr(`MMIC_POLL_ADDR, 32'h0, 2'h2);
		wr(`MMIC_TCR_ADDR, 32'h02, 2'h0);
		tmr <= 3'h1;
		@(posedge clk);
		tmr <= 3'h0;
		rd(`MMIC_PEEK_ADDR, 32'h8008, PM, 2'h0);
		rd(`MMIC_INSV_ADDR, 32'h0, '1, 2'h0);
		rd(`MMIC_POLL_ADDR, 32'h8008, PM, 2'h0);
		rd(`MMIC_INSV_ADDR, 32'h1, '1, 2'h0);
		rd(`MMIC_POLL_ADDR, 32'h0, 32'h8000, 2'h0);
		rd(`MMIC_INSV_ADDR, 32'h1, '1, 2'h0);
		wr(`MMIC_EOI_ADDR, 32'h8000, 2'h0);
		rd(`MMIC_INSV_ADDR, 32'h0, '1, 2'h0);
		wr(`MMIC_X0CR_ADDR, 32'h05, 2'h0);
		wr(`MMIC_X1CR_ADDR, 32'h03, 2'h0);
		wr(`MMIC_D0CR_ADDR, 32'h06, 2'h0);
		x0 <= 1'b1;
		intack(8'h0c);
		x1 <= 1'b1;
		intack(8'h0d);
		x1 <= 1'b0;
		dma <= 2'h1;
		@(posedge clk);
		dma <= 2'h0;
		rd(`MMIC_PEEK_ADDR, 32'h0, 32'h8000, 2'h0);
		wr(`MMIC_EOI_ADDR, 32'h000d, 2'h0);
		rd(`MMIC_INSV_ADDR, 32'h10, '1, 2'h0);
		rd(`MMIC_PEEK_ADDR, 32'h0, 32'h8000, 2'h0);
		wr(`MMIC_EOI_ADDR, 32'h8000, 2'h0);
		rd(`MMIC_POLL_ADDR, 32'h800a, PM, 2'h0);
		x0 <= 1'b0;
		wr(`MMIC_EOI_ADDR, 32'h8000, 2'h0);
		wr(`MMIC_X0CR_ADDR, 32'h21, 2'h0);
		// Pin enables follow the control register one clock later
		@(posedge clk);
		`CHK("oe_pair0", 1'b1, a0oe)
		`CHK("oe_pair1", 1'b0, a1oe)
		v = 8'($urandom());
		fire_ext(v);
		intack(v);
		v = 8'($urandom());
		fire_ext(v);
		repeat (4) @(posedge clk);
		rd(`MMIC_PEEK_ADDR, 32'h0, 32'h8000, 2'h0);
		wr(`MMIC_X0CR_ADDR, 32'h61, 2'h0);
		intack(v);
		rd(`MMIC_INSV_ADDR, 32'h10, '1, 2'h0);
		wr(`MMIC_EOI_ADDR, 32'h8000, 2'h0);
		rd(`MMIC_INSV_ADDR, 32'h0, '1, 2'h0);
		wr(`MMIC_X1CR_ADDR, 32'h13, 2'h0);
		x1 <= 1'b1;
		intack(8'h0d);
		wr(`MMIC_EOI_ADDR, 32'h8000, 2'h0);
		intack(8'h0d);
		x1 <= 1'b0;
		wr(`MMIC_EOI_ADDR, 32'h8000, 2'h0);
		tmr <= 3'h6;
		@(posedge clk);
		tmr <= 3'h0;
		rd(`MMIC_POLL_ADDR, 32'h8012, PM, 2'h0);
		wr(`MMIC_EOI_ADDR, 32'h8000, 2'h0);
		rd(`MMIC_POLL_ADDR, 32'h8013, PM, 2'h0);
		wr(`MMIC_EOI_ADDR, 32'h8000, 2'h0);
		wr(`MMIC_MASK_ADDR, 32'h81, 2'h0);
		rd(`MMIC_TCR_ADDR, 32'h0a, '1, 2'h0);
		tmr <= 3'h1;
		@(posedge clk);
		tmr <= 3'h0;
		rd(`MMIC_PEEK_ADDR, 32'h0, 32'h8000, 2'h0);
		wr(`MMIC_RELOC_ADDR, 32'h4000, 2'h0);
		// Mode output follows the relocation bit one clock later
		@(posedge clk);
		`CHK("slave", 1'b1, slave)
		wr(`MMIC_RELOC_ADDR, 32'h0, 2'h0);
		nmi <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("halt", 1'b1, halt)
		test_done;
	end
endmodule
`default_nettype wire
